// file: common/ebi_pkg.sv
`default_nettype none
package ebi_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OPND_W = 32;

  // Half-clock phases of one bus cycle; even phases have the bus clock high
  localparam logic [2:0] PH_S0 = 3'h0;
  localparam logic [2:0] PH_S1 = 3'h1;
  localparam logic [2:0] PH_S2 = 3'h2;
  localparam logic [2:0] PH_S3 = 3'h3;
  localparam logic [2:0] PH_S4 = 3'h4;
  localparam logic [2:0] PH_S5 = 3'h5;

  // Operand size and size-output codes: bytes still to move, 4 coded as 0
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // Acknowledge codes, active low: bit 1 alone = 16-bit port, bit 0 alone = 8-bit
  localparam logic [1:0] ACK_NONE = 2'h3;
  localparam logic [1:0] ACK_P8   = 2'h2;

  // Bus monitor: longest time-out in bus clocks, counted in half-clock steps
  localparam int         MON_MAX_CLK  = 64;
  localparam logic [7:0] MON_MAX_HALF = 8'(MON_MAX_CLK * 2);

  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [23:0] RST_ADDR = 24'h000000;

  typedef enum logic [2:0] {
    EBI_IDLE  = 3'b001,
    EBI_CYCLE = 3'b010,
    EBI_YIELD = 3'b100
  } ebi_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [1:0]        size;
    logic              read;
    logic [2:0]        space;
    logic [OPND_W-1:0] wdata;
  } ebi_req_t;

  typedef struct packed {
    logic [OPND_W-1:0] rdata;
    logic              fault;
  } ebi_rsp_t;
endpackage
`default_nettype wire

// file: design/ebi_port.sv
`default_nettype none
module ebi_port (
  input  wire logic              core_clk_in,
  input  wire logic              rstn_in,
  input  wire logic              req_valid_in,
  input  wire ebi_pkg::ebi_req_t req_in,
  output logic                   req_ready_out,
  output logic                   done_out,
  output ebi_pkg::ebi_rsp_t      rsp_out,
  input  wire logic [1:0]        monitor_sel_in,
  input  wire logic              single_chip_in,
  input  wire logic              partial_in,
  input  wire logic [1:0]        port_width_ack_n_in,
  input  wire logic              bus_fault_n_in,
  input  wire logic [15:0]       data_in,
  input  wire logic              bus_req_n_in,
  input  wire logic              bus_grant_ack_n_in,
  output logic [23:0]            addr_out,
  output logic [15:0]            data_out,
  output logic                   data_oe_n_out,
  output logic                   bus_oe_n_out,
  output logic                   addr_strobe_n_out,
  output logic                   data_strobe_n_out,
  output logic                   rw_out,
  output logic [1:0]             siz_out,
  output logic [2:0]             space_code_out,
  output logic                   sys_clock_out,
  output logic                   bus_grant_n_out
);
  localparam int SW = 23;

  logic [SW-1:0]       sync_s;
  logic [1:0]          ack_s;
  logic                fault_s;
  logic [15:0]         din_s;
  logic                breq_s;
  logic                bgack_s;
  logic                single_s;
  logic                partial_s;

  ebi_pkg::ebi_state_t st_q;
  ebi_pkg::ebi_state_t st_d;
  logic [2:0]          ph_q;
  logic [2:0]          ph_d;
  logic [2:0]          rem_q;
  logic [23:0]         addr_q;
  logic [31:0]         wbuf_q;
  logic [31:0]         rbuf_q;
  logic                rw_q;
  logic [2:0]          space_q;
  logic [1:0]          siz_q;
  logic [7:0]          mon_q;
  logic                fault_q;
  logic                as_n_q;
  logic                dstb_n_q;
  logic                doe_n_q;
  logic [15:0]         dout_q;
  logic                clk_q;
  logic                bg_n_q;
  logic                boe_n_q;
  logic                ready_q;
  logic                done_q;
  ebi_pkg::ebi_rsp_t   rsp_q;

  logic                take;
  logic                in_cyc;
  logic                ack_seen;
  logic                fault_seen;
  logic                tmo_seen;
  logic                term;
  logic                port16;
  logic [2:0]          mv;
  logic                last;

  function automatic logic [2:0] rem_of(input logic [1:0] sz);
    rem_of = (sz == ebi_pkg::SZ_LONG) ? 3'h4 : {1'b0, sz};
  endfunction

  function automatic logic [7:0] mon_limit(input logic [1:0] sel);
    mon_limit = ebi_pkg::MON_MAX_HALF >> sel;
  endfunction

  // Two bytes move only when aligned, at least two remain and the port is wide
  function automatic logic two_bytes(input logic wide, input logic a0,
                                     input logic [2:0] rem);
    two_bytes = wide && !a0 && (rem >= 3'h2);
  endfunction

  // Every pin input and strap except monitor_sel_in is resolved by two flops first
  ebi_sync #(
    .W       (SW),
    .RST_VAL ({2'h3, 1'b1, 16'h0000, 1'b1, 1'b1, 1'b0, 1'b0})
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .d_in        ({port_width_ack_n_in, bus_fault_n_in, data_in, bus_req_n_in,
                   bus_grant_ack_n_in, single_chip_in, partial_in}),
    .q_out       (sync_s)
  );

  assign {ack_s, fault_s, din_s, breq_s, bgack_s, single_s, partial_s} = sync_s;

  assign take      = req_valid_in && ready_q;
  assign in_cyc    = (st_q == ebi_pkg::EBI_CYCLE);
  assign ack_seen  = (ack_s != ebi_pkg::ACK_NONE);
  assign fault_seen = !fault_s;
  assign tmo_seen  = (mon_q >= mon_limit(monitor_sel_in));
  assign term      = in_cyc && (ph_q == ebi_pkg::PH_S4) && (ack_seen || fault_seen || tmo_seen);
  assign port16    = !partial_s && (ack_s != ebi_pkg::ACK_P8);
  assign mv        = two_bytes(port16, addr_q[0], rem_q) ? 3'h2 : 3'h1;
  assign last      = (rem_q == 3'h0) || fault_q;

  // Sequencer in half-clock steps; a cycle only starts when the bus clock rises
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    unique case (st_q)
      ebi_pkg::EBI_IDLE: begin
        if (take && !single_s) begin
          st_d = ebi_pkg::EBI_CYCLE;
          ph_d = ebi_pkg::PH_S0;
        end else if (!take && !breq_s) begin
          st_d = ebi_pkg::EBI_YIELD;
        end
      end
      ebi_pkg::EBI_CYCLE: begin
        if (ph_q == ebi_pkg::PH_S4) begin
          ph_d = term ? ebi_pkg::PH_S5 : ebi_pkg::PH_S3;
        end else if (ph_q == ebi_pkg::PH_S5) begin
          ph_d = ebi_pkg::PH_S0;
          if (last) begin
            st_d = ebi_pkg::EBI_IDLE;
          end
        end else begin
          ph_d = ph_q + 3'h1;
        end
      end
      ebi_pkg::EBI_YIELD: begin
        if (breq_s && bgack_s) begin
          st_d = ebi_pkg::EBI_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= ebi_pkg::EBI_IDLE;
      ph_q <= ebi_pkg::PH_S0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
    end
  end

  // Bus clock is the core clock halved, so each phase is one core cycle
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= !clk_q;
    end
  end

  // Ready only while the bus clock is low, so the next phase is S0 with it high
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (st_d == ebi_pkg::EBI_IDLE) && clk_q && !take;
    end
  end

  // Ownership: grant away only from idle, and release the pins while it lasts
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bg_n_q  <= 1'b1;
      boe_n_q <= 1'b1;
    end else begin
      bg_n_q  <= (st_d != ebi_pkg::EBI_YIELD);
      boe_n_q <= (st_d == ebi_pkg::EBI_YIELD) || single_s;
    end
  end

  // Cycle attributes: direction and space set only when an operand is taken
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rw_q    <= 1'b1;
      space_q <= 3'h0;
    end else if (take && !single_s) begin
      rw_q    <= req_in.read;
      space_q <= req_in.space;
    end
  end

  // Address and bytes left advance at termination; size outputs follow in S5 when bytes remain
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_q <= ebi_pkg::RST_ADDR;
      rem_q  <= 3'h0;
      siz_q  <= ebi_pkg::SZ_BYTE;
    end else if (take && !single_s) begin
      addr_q <= req_in.addr;
      rem_q  <= rem_of(req_in.size);
      siz_q  <= req_in.size;
    end else if (term) begin
      addr_q <= addr_q + {21'h000000, mv};
      rem_q  <= rem_q - mv;
    end else if (in_cyc && ph_q == ebi_pkg::PH_S5 && !last) begin
      siz_q  <= rem_q[1:0];
    end
  end

  // Write operand left-justified so the first byte is always on top
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wbuf_q <= 32'h00000000;
    end else if (take) begin
      wbuf_q <= req_in.wdata << {3'(3'h4 - rem_of(req_in.size)), 3'h0};
    end else if (term) begin
      wbuf_q <= wbuf_q << {mv, 3'h0};
    end
  end

  // Read bytes shift in at the falling edge ending S4, right-justified at the end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rbuf_q <= 32'h00000000;
    end else if (take) begin
      rbuf_q <= 32'h00000000;
    end else if (term && rw_q && ack_seen) begin
      if (mv == 3'h2) begin
        rbuf_q <= {rbuf_q[15:0], din_s};
      end else if (port16 && addr_q[0]) begin
        rbuf_q <= {rbuf_q[23:0], din_s[7:0]};
      end else begin
        rbuf_q <= {rbuf_q[23:0], din_s[15:8]};
      end
    end
  end

  // Monitor runs from S0 of each cycle and cannot be turned off
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mon_q <= 8'h00;
    end else if (!in_cyc || ph_q == ebi_pkg::PH_S5) begin
      mon_q <= 8'h00;
    end else if (mon_q != 8'hff) begin
      mon_q <= mon_q + 8'h01;
    end
  end

  // A fault ends the whole operand, not just the current bus cycle
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_q <= 1'b0;
    end else if (take) begin
      fault_q <= 1'b0;
    end else if (term && (fault_seen || !ack_seen)) begin
      fault_q <= 1'b1;
    end
  end

  // Strobes: address strobe at S1, read data strobe with it, write one clock later
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      as_n_q   <= 1'b1;
      dstb_n_q <= 1'b1;
    end else if (in_cyc) begin
      if (ph_d == ebi_pkg::PH_S1) begin
        as_n_q   <= 1'b0;
        dstb_n_q <= !rw_q;
      end else if (ph_d == ebi_pkg::PH_S3) begin
        dstb_n_q <= 1'b0;
      end else if (ph_d == ebi_pkg::PH_S5) begin
        as_n_q   <= 1'b1;
        dstb_n_q <= 1'b1;
      end
    end
  end

  // Write data from S2; a lone byte is copied to both lanes when the partial strap, an odd address or one byte left rules out two
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      doe_n_q <= 1'b1;
      dout_q  <= ebi_pkg::RST_DATA;
    end else if (in_cyc && ph_d == ebi_pkg::PH_S2 && !rw_q) begin
      doe_n_q <= 1'b0;
      if (two_bytes(!partial_s, addr_q[0], rem_q)) begin
        dout_q <= wbuf_q[31:16];
      end else begin
        dout_q <= {wbuf_q[31:24], wbuf_q[31:24]};
      end
    end else if (in_cyc && ph_q == ebi_pkg::PH_S5) begin
      doe_n_q <= 1'b1;
    end
  end

  // Completion; a request in single-chip mode is answered at once with a fault
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_q <= 1'b0;
      rsp_q  <= '0;
    end else if (take && single_s) begin
      done_q      <= 1'b1;
      rsp_q.rdata <= 32'h00000000;
      rsp_q.fault <= 1'b1;
    end else if (in_cyc && ph_q == ebi_pkg::PH_S5 && last) begin
      done_q      <= 1'b1;
      rsp_q.rdata <= rbuf_q;
      rsp_q.fault <= fault_q;
    end else begin
      done_q <= 1'b0;
    end
  end

  assign req_ready_out     = ready_q;
  assign done_out          = done_q;
  assign rsp_out           = rsp_q;
  assign addr_out          = addr_q;
  assign data_out          = dout_q;
  assign data_oe_n_out     = doe_n_q;
  assign bus_oe_n_out      = boe_n_q;
  assign addr_strobe_n_out = as_n_q;
  assign data_strobe_n_out = dstb_n_q;
  assign rw_out            = rw_q;
  assign siz_out           = siz_q;
  assign space_code_out    = space_q;
  assign sys_clock_out     = clk_q;
  assign bus_grant_n_out   = bg_n_q;

  property p_as_half;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (in_cyc && ph_q == ebi_pkg::PH_S0) |=> !as_n_q && !clk_q;
  endproperty
  a_as_half: assert property (p_as_half) else $error("Address strobe not half clock late");

  property p_rd_dstb;
    @(posedge core_clk_in) disable iff (!rstn_in)
    ($fell(as_n_q) && rw_q) |-> !dstb_n_q;
  endproperty
  a_rd_dstb: assert property (p_rd_dstb) else $error("Read data strobe late");

  property p_wr_dstb;
    @(posedge core_clk_in) disable iff (!rstn_in)
    ($fell(as_n_q) && !rw_q) |-> dstb_n_q ##1 dstb_n_q ##1 !dstb_n_q;
  endproperty
  a_wr_dstb: assert property (p_wr_dstb) else $error("Write data strobe not one clock late");

  property p_wr_data;
    @(posedge core_clk_in) disable iff (!rstn_in)
    ($fell(as_n_q) && !rw_q) |-> doe_n_q ##1 !doe_n_q;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("Write data not half clock late");

  property p_rw_start;
    @(posedge core_clk_in) disable iff (!rstn_in)
    $changed(rw_q) |-> (in_cyc && ph_q == ebi_pkg::PH_S0);
  endproperty
  a_rw_start: assert property (p_rw_start) else $error("Direction changed mid cycle");

  property p_addr_hold;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (!as_n_q && $past(!as_n_q)) |-> $stable(addr_q) && $stable(siz_q) && $stable(space_q);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("Address moved under strobe");

  property p_single;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (take && single_s) |=> done_q && rsp_q.fault && as_n_q;
  endproperty
  a_single: assert property (p_single) else $error("Bus used in single-chip mode");

  property p_monitor;
    @(posedge core_clk_in) disable iff (!rstn_in)
    in_cyc |-> (mon_q <= ebi_pkg::MON_MAX_HALF + 8'h02);
  endproperty
  a_monitor: assert property (p_monitor) else $error("Bus monitor overran");

  property p_release;
    @(posedge core_clk_in) disable iff (!rstn_in)
    done_q |-> as_n_q && dstb_n_q && doe_n_q;
  endproperty
  a_release: assert property (p_release) else $error("Bus not released at end");

  property p_wait;
    @(posedge core_clk_in) disable iff (!rstn_in)
    (in_cyc && ph_q == ebi_pkg::PH_S4 && !term) |=> (ph_q == ebi_pkg::PH_S3) && !as_n_q;
  endproperty
  a_wait: assert property (p_wait) else $error("Wait state not whole clock");

  c_read:  cover property (@(posedge core_clk_in) done_q && !rsp_q.fault && rw_q);
  c_write: cover property (@(posedge core_clk_in) done_q && !rsp_q.fault && !rw_q);
  c_fault: cover property (@(posedge core_clk_in) done_q && rsp_q.fault && !single_s);
  c_yield: cover property (@(posedge core_clk_in) !bg_n_q);
endmodule
`default_nettype wire

// file: design/ebi_sync.sv
`default_nettype none
// Two-stage synchroniser; only the second stage leaves the module
module ebi_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: verification/ebi_mem_model.sv
`default_nettype none
// Memory on the far side of the bus; port width, wait states and faults set by the bench
module ebi_mem_model (
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [15:0] data_in,
  input  wire logic        addr_strobe_n_in,
  input  wire logic        data_strobe_n_in,
  input  wire logic        rw_in,
  input  wire logic [1:0]  siz_in,
  input  wire logic        port8_in,
  input  wire logic [3:0]  wait_in,
  input  wire logic        fault_in,
  input  wire logic        mute_in,
  output logic      [1:0]  port_width_ack_n_out,
  output logic             bus_fault_n_out,
  output logic      [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [256];
  logic [4:0]  cnt;
  logic [15:0] last;
  logic [7:0]  a;
  logic        drv;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  assign a   = addr_in[7:0];
  assign drv = !addr_strobe_n_in && !data_strobe_n_in && rw_in;
  // Undriven bus shows a changing pattern so a stale value is never latched by luck
  always_comb begin
    if (!drv) data_out = ~last;
    else if (port8_in) data_out = {mem[a], ~mem[a]};
    else data_out = {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]};
  end
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 5'h00;
      last <= 16'h0000;
      port_width_ack_n_out <= 2'h3;
      bus_fault_n_out <= 1'b1;
    end else begin
      last <= data_out;
      if (addr_strobe_n_in) begin
        cnt <= 5'h00;
        port_width_ack_n_out <= 2'h3;
        bus_fault_n_out <= 1'b1;
      end else if (!data_strobe_n_in) begin
        cnt <= cnt + 5'h01;
        if (cnt == {1'b0, wait_in}) begin
          if (!rw_in && port8_in) mem[a] <= data_in[15:8];
          else if (!rw_in && (siz_in == 2'h1 || a[0])) mem[a] <= a[0] ? data_in[7:0] : data_in[15:8];
          else if (!rw_in) begin
            mem[a] <= data_in[15:8];
            mem[a + 8'h01] <= data_in[7:0];
          end
          if (fault_in) bus_fault_n_out <= 1'b0;
          else if (!mute_in) port_width_ack_n_out <= port8_in ? 2'h2 : 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/test_ebi_port.sv
`default_nettype none
module test_ebi_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rstn, req_valid, ready, done, single, partial, fault_n, cyc_rw;
  logic              breq_n, gack_n, doe_n, boe_n, as_n, dstb_n, rw, sclk, bgnt_n;
  logic              port8, flt, mute, exp_rd, as_prev;
  logic [1:0]        mon_sel, ack_n, siz;
  logic [2:0]        sp, exp_sp;
  logic [3:0]        waitc;
  logic [15:0]       bus, dout, mdl_d, siz_pk;
  logic [23:0]       addr, cyc_a;
  logic [31:0]       alow_pk;
  ebi_pkg::ebi_req_t req;
  ebi_pkg::ebi_rsp_t rsp;
  int                bad_count, check_count, ncyc, cnt, dstb_dly, oe_dly, dur, base, tick;
  // Resolved data wire: the port drives while its enable is low
  assign bus = doe_n ? mdl_d : dout;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ebi_port u_ebi_port (.core_clk_in(clk), .rstn_in(rstn), .req_valid_in(req_valid),
    .req_in(req), .req_ready_out(ready), .done_out(done), .rsp_out(rsp),
    .monitor_sel_in(mon_sel), .single_chip_in(single), .partial_in(partial),
    .port_width_ack_n_in(ack_n), .bus_fault_n_in(fault_n), .data_in(bus),
    .bus_req_n_in(breq_n), .bus_grant_ack_n_in(gack_n), .addr_out(addr), .data_out(dout),
    .data_oe_n_out(doe_n), .bus_oe_n_out(boe_n), .addr_strobe_n_out(as_n),
    .data_strobe_n_out(dstb_n), .rw_out(rw), .siz_out(siz), .space_code_out(sp),
    .sys_clock_out(sclk), .bus_grant_n_out(bgnt_n));
  ebi_mem_model u_ebi_mem_model (.core_clk_in(clk), .rstn_in(rstn), .addr_in(addr),
    .data_in(bus), .addr_strobe_n_in(as_n), .data_strobe_n_in(dstb_n), .rw_in(rw),
    .siz_in(siz), .port8_in(port8), .wait_in(waitc), .fault_in(flt), .mute_in(mute),
    .port_width_ack_n_out(ack_n), .bus_fault_n_out(fault_n), .data_out(mdl_d));
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_op(input logic rd, input logic [1:0] sz, input logic [23:0] a,
                       input logic [31:0] wd, input logic [2:0] s);
    int n;
    n = 0;
    exp_rd = rd;
    exp_sp = s;
    ncyc = 0;
    siz_pk = 16'h0000;
    alow_pk = 32'h00000000;
    req = '{addr: a, size: sz, read: rd, space: s, wdata: wd};
    req_valid = 1'b1;
    while (ready !== 1'b1 && n < 100) begin
      wcyc(1);
      n++;
    end
    wcyc(1);
    req_valid = 1'b0;
    dur = 0;
    while (done !== 1'b1 && dur < 400) begin
      wcyc(1);
      dur++;
    end
    chk(32'(done), 32'h1);
  endtask
  task automatic chk_log(input int n, input logic [15:0] s, input logic [31:0] al);
    chk(32'(ncyc), 32'(n));
    chk(32'(siz_pk), 32'(s));
    chk(alow_pk, al);
    chk(32'(rsp.fault), 32'h0);
  endtask
  // Per bus cycle: strobe phasing, held address and controls, release at the end
  always @(negedge clk) begin
    if (rstn && !as_n && as_prev) begin
      ncyc++;
      siz_pk = {siz_pk[13:0], siz};
      alow_pk = {alow_pk[23:0], addr[7:0]};
      cyc_a = addr;
      cyc_rw = rw;
      cnt = 0;
      dstb_dly = -1;
      oe_dly = -1;
      chk(32'(sclk), 32'h0);
      chk(32'({sp, rw}), 32'({exp_sp, exp_rd}));
    end else if (!as_n) begin
      cnt++;
      chk(32'({addr, rw}), 32'({cyc_a, cyc_rw}));
    end else if (!as_prev) begin
      chk(32'(dstb_n), 32'h1);
      chk(32'(dstb_dly), exp_rd ? 32'h0 : 32'h2);
      if (!exp_rd) chk(32'(oe_dly), 32'h1);
      cnt = -1;
    end else if (cnt == -1) begin
      chk(32'(doe_n), 32'h1);
      cnt = -2;
    end
    if (!as_n && !dstb_n && dstb_dly < 0) dstb_dly = cnt;
    if (!as_n && !doe_n && oe_dly < 0) oe_dly = cnt;
    as_prev = as_n;
  end
  task automatic t_wide16();
    do_op(1'b0, ebi_pkg::SZ_LONG, 24'h000020, 32'h11223344, 3'h5);
    chk_log(2, 16'h0002, 32'h00002022);
    do_op(1'b1, ebi_pkg::SZ_LONG, 24'h000020, 32'h0, 3'h5);
    base = dur;
    chk_log(2, 16'h0002, 32'h00002022);
    chk(rsp.rdata, 32'h11223344);
  endtask
  task automatic t_odd();
    do_op(1'b0, ebi_pkg::SZ_WORD, 24'h000031, 32'h0000beef, 3'h1);
    chk_log(2, 16'h0009, 32'h00003132);
    do_op(1'b1, ebi_pkg::SZ_WORD, 24'h000031, 32'h0, 3'h1);
    chk(rsp.rdata, 32'h0000beef);
    do_op(1'b1, ebi_pkg::SZ_BYTE, 24'h000032, 32'h0, 3'h2);
    chk_log(1, 16'h0001, 32'h00000032);
    chk(rsp.rdata, 32'h000000ef);
    do_op(1'b1, ebi_pkg::SZ_WORD, 24'h000030, 32'h0, 3'h2);
    chk_log(1, 16'h0002, 32'h00000030);
    chk(rsp.rdata, 32'h000000be);
  endtask
  task automatic t_port8();
    port8 = 1'b1;
    do_op(1'b0, ebi_pkg::SZ_LONG, 24'h000040, 32'hcafe1234, 3'h6);
    chk_log(4, 16'h0039, 32'h40414243);
    do_op(1'b1, ebi_pkg::SZ_LONG, 24'h000040, 32'h0, 3'h6);
    chk(rsp.rdata, 32'hcafe1234);
    port8 = 1'b0;
  endtask
  task automatic t_partial();
    partial = 1'b1;
    wcyc(4);
    do_op(1'b0, ebi_pkg::SZ_WORD, 24'h000050, 32'h00005678, 3'h1);
    chk_log(2, 16'h0009, 32'h00005051);
    partial = 1'b0;
    wcyc(4);
  endtask
  task automatic t_space();
    for (int i = 0; i < 8; i++) begin
      do_op(1'b1, ebi_pkg::SZ_BYTE, 24'h000020, 32'h0, 3'(i));
      chk(rsp.rdata, 32'h00000011);
    end
  endtask
  task automatic t_wait();
    waitc = 4'h5;
    do_op(1'b1, ebi_pkg::SZ_LONG, 24'h000020, 32'h0, 3'h5);
    chk(rsp.rdata, 32'h11223344);
    chk(32'((dur - base) % 2 == 0 && dur > base), 32'h1);
    waitc = 4'h0;
  endtask
  task automatic t_fault();
    flt = 1'b1;
    do_op(1'b1, ebi_pkg::SZ_LONG, 24'h000020, 32'h0, 3'h5);
    chk(32'(rsp.fault), 32'h1);
    chk(32'(ncyc), 32'h1);
    flt = 1'b0;
  endtask
  task automatic t_timeout();
    int lim;
    mute = 1'b1;
    for (int s = 0; s < 4; s++) begin
      mon_sel = 2'(s);
      lim = 128 >> s;
      do_op(1'b1, ebi_pkg::SZ_WORD, 24'h000020, 32'h0, 3'h5);
      chk(32'(rsp.fault), 32'h1);
      chk(32'(dur >= lim && dur <= lim + 8), 32'h1);
    end
    mute = 1'b0;
    mon_sel = 2'h0;
  endtask
  task automatic t_single();
    single = 1'b1;
    wcyc(4);
    do_op(1'b1, ebi_pkg::SZ_WORD, 24'h000020, 32'h0, 3'h5);
    chk(32'({rsp.fault, boe_n}), 32'h3);
    chk(32'(ncyc == 0 && dur <= 2), 32'h1);
    single = 1'b0;
    wcyc(4);
  endtask
  task automatic t_arb();
    int n;
    n = 0;
    breq_n = 1'b0;
    while (bgnt_n !== 1'b0 && n < 10) begin
      wcyc(1);
      n++;
    end
    chk(32'({bgnt_n, boe_n}), 32'h1);
    gack_n = 1'b0;
    breq_n = 1'b1;
    wcyc(4);
    chk(32'(boe_n), 32'h1);
    gack_n = 1'b1;
    wcyc(6);
    chk(32'(bgnt_n), 32'h1);
    do_op(1'b1, ebi_pkg::SZ_BYTE, 24'h000020, 32'h0, 3'h5);
    chk(rsp.rdata, 32'h00000011);
  endtask
  always @(posedge clk) begin
    tick++;
    if (tick > 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    mon_sel = 2'h0;
    single = 1'b0;
    partial = 1'b0;
    breq_n = 1'b1;
    gack_n = 1'b1;
    port8 = 1'b0;
    waitc = 4'h0;
    flt = 1'b0;
    mute = 1'b0;
    exp_rd = 1'b1;
    exp_sp = 3'h0;
    as_prev = 1'b1;
    wcyc(10);
    rstn = 1'b1;
    wcyc(4);
    t_wide16();
    t_odd();
    t_port8();
    t_partial();
    t_space();
    t_wait();
    t_fault();
    t_timeout();
    t_single();
    t_arb();
    print_verdict();
  end
endmodule
`default_nettype wire
